// >>> fepp_pkg.sv
// constants for the flash erase/program/protect sequencer
package fepp_pkg;
    localparam logic [7:0] OP_SECTOR_ERASE = 8'h7C;
    localparam logic [7:0] OP_PROG_BUF1 = 8'h82;
    localparam logic [7:0] OP_PROG_BUF2 = 8'h85;
    localparam logic [7:0] SEQ_CHIP_0 = 8'hC7;
    localparam logic [7:0] SEQ_CHIP_1 = 8'h94;
    localparam logic [7:0] SEQ_CHIP_2 = 8'h80;
    localparam logic [7:0] SEQ_CHIP_3 = 8'h9A;
    localparam logic [7:0] SEQ_PROT_0 = 8'h3D;
    localparam logic [7:0] SEQ_PROT_1 = 8'h2A;
    localparam logic [7:0] SEQ_PROT_2 = 8'h7F;
    localparam logic [7:0] SEQ_PROT_EN = 8'hA9;
    localparam logic [7:0] SEQ_PROT_DIS = 8'h9A;
    localparam logic [7:0] SECT_PROTECTED = 8'hFF;
    localparam int NUM_SECTORS = 16;
    localparam int BUF_DEPTH = 264;
    localparam int BUF_AW = 9;
    localparam logic [8:0] BUF_LAST_264 = 9'h107;
    localparam logic [8:0] BUF_LAST_256 = 9'h0FF;
    localparam logic [2:0] HDR_BYTES = 3'h4;
    localparam logic [3:0] SECT_0A = 4'h0;
    localparam logic [4:0] SECT_0B_CODE = 5'h10;
    localparam int CLK_MHZ = 40;
    localparam int T_ERASE_US = 100;
    localparam int T_PROG_US = 50;
    localparam int ERASE_CYCLES = T_ERASE_US * CLK_MHZ;
    localparam int PROG_CYCLES = T_PROG_US * CLK_MHZ;
    localparam int CHIP_CYCLES_DEF = 8 * ERASE_CYCLES;
    localparam int TMR_W = 24;
    typedef enum logic [2:0] {OP_NONE, OP_SECT, OP_CHIP, OP_PROG, OP_PEN, OP_PDIS} fepp_op_t;
endpackage

// >>> fepp_core.sv
// command sequencer for erase, buffered page program and sector protection
`timescale 1ns/1ps
`default_nettype none
module fepp_core #(
    parameter int CHIP_CYCLES = fepp_pkg::CHIP_CYCLES_DEF
) (
    input wire logic clock_in, // 40 MHz system clock
    input wire logic resetn_in, // async reset, active low
    input wire logic cs_n_in, // chip select pin, active low
    input wire logic sck_in, // serial clock pin
    input wire logic si_in, // serial data pin
    input wire logic wp_n_in, // write protect pin, active low, pulled high
    input wire logic page_256_in, // 1 selects 256-byte page mode
    input wire logic [8*fepp_pkg::NUM_SECTORS-1:0] sect_sel_in, // selection register bytes
    input wire logic [fepp_pkg::NUM_SECTORS-1:0] lockdown_in, // per-sector lockdown
    input wire logic [1:0] rd_buf_in, // buffer readback select, one-hot
    input wire logic [fepp_pkg::BUF_AW-1:0] rd_addr_in, // buffer readback address
    output logic busy_out, // self-timed operation running
    output logic prot_en_out, // sector protection enabled (status)
    output logic [7:0] rd_data_out, // buffer readback data
    output logic op_valid_out, // array operation word valid
    output logic [2:0] op_kind_out, // fepp_op_t of the operation
    output logic [fepp_pkg::NUM_SECTORS-1:0] op_sect_mask_out, // sectors to erase
    output logic [11:0] op_page_out, // target page of a program
    output logic op_buf_out, // buffer used by a program
    input wire logic op_ready_in // array side accepts operation
);
    import fepp_pkg::*;

    // ------------------------------------------------------------
    // pin synchronisers and edges
    // ------------------------------------------------------------
    logic [2:0] cs_sync_reg, sck_sync_reg;
    logic [1:0] si_sync_reg, wp_sync_reg;
    always_ff @(posedge clock_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            cs_sync_reg <= 3'h7;
            sck_sync_reg <= 3'h0;
            si_sync_reg <= 2'h0;
            wp_sync_reg <= 2'h3;
        end
        else
        begin
            cs_sync_reg <= {cs_sync_reg[1:0], cs_n_in};
            sck_sync_reg <= {sck_sync_reg[1:0], sck_in};
            si_sync_reg <= {si_sync_reg[0], si_in};
            wp_sync_reg <= {wp_sync_reg[0], wp_n_in};
        end
    end
    wire cs_low = ~cs_sync_reg[1];
    wire cs_rise = cs_sync_reg[1] & ~cs_sync_reg[2];
    wire sck_rise = sck_sync_reg[1] & ~sck_sync_reg[2] & cs_low;
    wire si_bit = si_sync_reg[1];
    wire wp_asserted = ~wp_sync_reg[1];

    // ------------------------------------------------------------
    // byte assembly
    // ------------------------------------------------------------
    logic [2:0] bit_cnt_reg;
    logic [6:0] shift_reg;
    logic [2:0] byte_cnt_reg; // saturates after header
    logic [7:0] b0_reg, b1_reg, b2_reg, b3_reg;
    logic [BUF_AW-1:0] bptr_reg;
    wire byte_done = sck_rise & (bit_cnt_reg == 3'h7);
    wire [7:0] new_byte = {shift_reg, si_bit};
    wire in_data = byte_cnt_reg == HDR_BYTES;
    wire is_prog = (b0_reg == OP_PROG_BUF1) | (b0_reg == OP_PROG_BUF2);
    wire [BUF_AW-1:0] buf_last = page_256_in ? BUF_LAST_256 : BUF_LAST_264;
    // start byte: 9 bits in 264 mode, 8 bits in 256 mode
    wire [BUF_AW-1:0] start_264 = {b2_reg[0], new_byte};
    wire [BUF_AW-1:0] start_256 = {1'b0, new_byte};
    wire data_wr = byte_done & in_data & is_prog & ~busy_out;
    always_ff @(posedge clock_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            bit_cnt_reg <= 3'h0;
            shift_reg <= 7'h00;
            byte_cnt_reg <= 3'h0;
            b0_reg <= 8'h00;
            b1_reg <= 8'h00;
            b2_reg <= 8'h00;
            b3_reg <= 8'h00;
            bptr_reg <= '0;
        end
        else if (!cs_low)
        begin
            bit_cnt_reg <= 3'h0;
            if (cs_rise)
                byte_cnt_reg <= 3'h0;
        end
        else if (sck_rise)
        begin
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            shift_reg <= new_byte[6:0];
            if (byte_done)
            begin
                case (byte_cnt_reg)
                    3'h0: b0_reg <= new_byte;
                    3'h1: b1_reg <= new_byte;
                    3'h2: b2_reg <= new_byte;
                    3'h3:
                    begin
                        b3_reg <= new_byte;
                        bptr_reg <= page_256_in ? start_256 : start_264;
                    end
                    default: ;
                endcase
                if (!in_data)
                    byte_cnt_reg <= byte_cnt_reg + 3'h1;
                else if (data_wr)
                    bptr_reg <= (bptr_reg >= buf_last) ? '0 : bptr_reg + 9'h001;
            end
        end
    end

    // ------------------------------------------------------------
    // two data buffers
    // ------------------------------------------------------------
    logic [7:0] buf1_mem [BUF_DEPTH];
    logic [7:0] buf2_mem [BUF_DEPTH];
    always_ff @(posedge clock_in)
    begin
        if (data_wr && b0_reg == OP_PROG_BUF1)
            buf1_mem[bptr_reg] <= new_byte;
        if (data_wr && b0_reg == OP_PROG_BUF2)
            buf2_mem[bptr_reg] <= new_byte;
    end
    always_ff @(posedge clock_in or negedge resetn_in)
    begin
        if (!resetn_in)
            rd_data_out <= 8'h00;
        else
            rd_data_out <= rd_buf_in[1] ? buf2_mem[rd_addr_in] : buf1_mem[rd_addr_in];
    end

    // ------------------------------------------------------------
    // command decode on select rise
    // ------------------------------------------------------------
    wire full_hdr = byte_cnt_reg == HDR_BYTES;
    wire prot_pre = (b0_reg == SEQ_PROT_0) & (b1_reg == SEQ_PROT_1) & (b2_reg == SEQ_PROT_2);
    wire cmd_pen = full_hdr & prot_pre & (b3_reg == SEQ_PROT_EN);
    wire cmd_pdis = full_hdr & prot_pre & (b3_reg == SEQ_PROT_DIS) & ~wp_asserted;
    wire cmd_chip = full_hdr & (b0_reg == SEQ_CHIP_0) & (b1_reg == SEQ_CHIP_1)
        & (b2_reg == SEQ_CHIP_2) & (b3_reg == SEQ_CHIP_3);
    wire cmd_sect = full_hdr & (b0_reg == OP_SECTOR_ERASE);
    wire cmd_prog = full_hdr & is_prog;
    // page index: 264 mode uses bits 20..9 of the address, 256 mode bits 19..8
    wire [23:0] addr = {b1_reg, b2_reg, b3_reg};
    wire [11:0] page_idx = page_256_in ? addr[19:8] : addr[20:9];
    wire page_top_zero = page_idx[11:4] == 8'h00;
    wire [4:0] sect_code = page_top_zero ? (page_idx[3] ? SECT_0B_CODE : 5'h00)
        : {1'b0, page_idx[11:8]};

    // ------------------------------------------------------------
    // protection set
    // ------------------------------------------------------------
    logic sw_prot_reg;
    logic wp_latched_reg; // pin level as seen by protection
    wire prot_active = sw_prot_reg | wp_latched_reg;
    wire [NUM_SECTORS-1:0] sect_guard;
    genvar gi;
    generate
        for (gi = 0; gi < NUM_SECTORS; gi++)
        begin : g_guard
            wire [7:0] sel_byte = sect_sel_in[8*gi +: 8];
            if (gi == 0)
            begin : g_zero
                // both halves of sector zero must be marked
                assign sect_guard[gi] = sel_byte[7:6] == 2'h3 && sel_byte[5:4] == 2'h3;
            end
            else
            begin : g_norm
                assign sect_guard[gi] = sel_byte == SECT_PROTECTED;
            end
        end
    endgenerate
    wire [NUM_SECTORS-1:0] blocked = (prot_active ? sect_guard : '0) | lockdown_in;
    wire [NUM_SECTORS-1:0] chip_mask = ~blocked;
    wire [NUM_SECTORS-1:0] sect_onehot = NUM_SECTORS'(1) << sect_code[3:0];
    wire [NUM_SECTORS-1:0] sect_mask = sect_onehot & chip_mask;
    wire [NUM_SECTORS-1:0] page_sect = NUM_SECTORS'(1) << page_idx[11:8];

    // ------------------------------------------------------------
    // self-timed engine
    // ------------------------------------------------------------
    typedef enum logic [1:0] {FEPP_IDLE, FEPP_ERASE, FEPP_PROG} fepp_state_t;
    fepp_state_t state_reg;
    logic [TMR_W-1:0] tmr_reg;
    logic kind_hold_reg; // running command is a program: erase phase then program phase
    wire start_op = cs_rise & (state_reg == FEPP_IDLE);
    wire go_sect = start_op & cmd_sect;
    wire go_chip = start_op & cmd_chip;
    wire go_prog = start_op & cmd_prog & ((page_sect & blocked) == '0);
    wire tmr_zero = tmr_reg == '0;
    always_ff @(posedge clock_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            state_reg <= FEPP_IDLE;
            tmr_reg <= '0;
            busy_out <= 1'b0;
        end
        else
        begin
            case (state_reg)
                FEPP_IDLE:
                begin
                    if (go_sect)
                    begin
                        state_reg <= FEPP_ERASE;
                        tmr_reg <= TMR_W'(ERASE_CYCLES);
                        busy_out <= 1'b1;
                    end
                    else if (go_chip)
                    begin
                        state_reg <= FEPP_ERASE;
                        tmr_reg <= TMR_W'(CHIP_CYCLES);
                        busy_out <= 1'b1;
                    end
                    else if (go_prog)
                    begin
                        state_reg <= FEPP_ERASE; // page erase first
                        tmr_reg <= TMR_W'(ERASE_CYCLES);
                        busy_out <= 1'b1;
                    end
                end
                FEPP_ERASE:
                begin
                    if (tmr_zero && kind_hold_reg)
                    begin
                        state_reg <= FEPP_PROG;
                        tmr_reg <= TMR_W'(PROG_CYCLES);
                    end
                    else if (tmr_zero)
                    begin
                        state_reg <= FEPP_IDLE;
                        busy_out <= 1'b0;
                    end
                    else
                        tmr_reg <= tmr_reg - TMR_W'(1);
                end
                FEPP_PROG:
                begin
                    if (tmr_zero)
                    begin
                        state_reg <= FEPP_IDLE;
                        busy_out <= 1'b0;
                    end
                    else
                        tmr_reg <= tmr_reg - TMR_W'(1);
                end
                default:
                begin
                    state_reg <= FEPP_IDLE;
                    busy_out <= 1'b0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // protection state
    // ------------------------------------------------------------
    always_ff @(posedge clock_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            sw_prot_reg <= 1'b0;
            wp_latched_reg <= 1'b0;
            prot_en_out <= 1'b0;
        end
        else
        begin
            if (start_op && cmd_pen)
                sw_prot_reg <= 1'b1;
            else if (start_op && cmd_pdis)
                sw_prot_reg <= 1'b0;
            // pin change held off while an erase runs
            if (state_reg != FEPP_ERASE)
                wp_latched_reg <= wp_asserted;
            prot_en_out <= prot_active;
        end
    end

    // ------------------------------------------------------------
    // two-entry buffer toward the array
    // ------------------------------------------------------------
    logic [1:0] q_cnt_reg;
    logic q_rd_reg;
    logic [2:0] q_kind_reg [2];
    logic [NUM_SECTORS-1:0] q_mask_reg [2];
    logic [11:0] q_page_reg [2];
    logic q_buf_reg [2];
    logic q_wr_reg;
    wire push = (go_sect | go_chip | go_prog) & (q_cnt_reg != 2'h2);
    wire pop = op_valid_out & op_ready_in;
    wire [2:0] push_kind = go_sect ? 3'(OP_SECT) : go_chip ? 3'(OP_CHIP) : 3'(OP_PROG);
    wire [NUM_SECTORS-1:0] push_mask = go_sect ? sect_mask : go_chip ? chip_mask : page_sect;
    always_ff @(posedge clock_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            q_cnt_reg <= 2'h0;
            q_rd_reg <= 1'b0;
            q_wr_reg <= 1'b0;
            q_kind_reg <= '{default: 3'h0};
            q_mask_reg <= '{default: '0};
            q_page_reg <= '{default: 12'h000};
            q_buf_reg <= '{default: 1'b0};
        end
        else
        begin
            if (push)
            begin
                q_kind_reg[q_wr_reg] <= push_kind;
                q_mask_reg[q_wr_reg] <= push_mask;
                q_page_reg[q_wr_reg] <= page_idx;
                q_buf_reg[q_wr_reg] <= b0_reg == OP_PROG_BUF2;
                q_wr_reg <= ~q_wr_reg;
            end
            if (pop)
                q_rd_reg <= ~q_rd_reg;
            q_cnt_reg <= q_cnt_reg + {1'b0, push} - {1'b0, pop};
        end
    end
    // head registered straight onto the outputs
    always_ff @(posedge clock_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            op_valid_out <= 1'b0;
            op_kind_out <= 3'(OP_NONE);
            op_sect_mask_out <= '0;
            op_page_out <= 12'h000;
            op_buf_out <= 1'b0;
            kind_hold_reg <= 1'b0;
        end
        else
        begin
            op_kind_out <= q_kind_reg[pop ? ~q_rd_reg : q_rd_reg];
            if (start_op)
                kind_hold_reg <= go_prog;
            // a word pushed on this edge is only shown once it is stored
            op_valid_out <= (q_cnt_reg == 2'h2) | ((q_cnt_reg == 2'h1) & ~pop);
            op_sect_mask_out <= q_mask_reg[pop ? ~q_rd_reg : q_rd_reg];
            op_page_out <= q_page_reg[pop ? ~q_rd_reg : q_rd_reg];
            op_buf_out <= q_buf_reg[pop ? ~q_rd_reg : q_rd_reg];
        end
    end
endmodule
`default_nettype wire

// >>> fepp_monitor.sv
// assertion checker for the flash command sequencer
`timescale 1ns/1ps
`default_nettype none
module fepp_monitor
    import fepp_pkg::*;
#(
    parameter int CHIP_CYCLES = 50
) (
    input wire logic clock_in, // clock
    input wire logic resetn_in, // reset, active low
    input wire logic cs_n_in, // chip select pin
    input wire logic wp_n_in, // protect pin
    input wire logic [8*fepp_pkg::NUM_SECTORS-1:0] sect_sel_in, // selection bytes
    input wire logic [fepp_pkg::NUM_SECTORS-1:0] lockdown_in, // lock levels
    input wire logic busy_out, // busy status
    input wire logic prot_en_out, // protection status
    input wire logic op_valid_out, // op word valid
    input wire logic [2:0] op_kind_out, // op kind
    input wire logic [fepp_pkg::NUM_SECTORS-1:0] op_sect_mask_out, // erase mask
    input wire logic [11:0] op_page_out, // program page
    input wire logic op_buf_out, // program buffer
    input wire logic op_ready_in // array accepts
);
    logic [NUM_SECTORS-1:0] guard;
    logic [15:0] busy_cnt;
    // under-approximates the guard set, so it never over-constrains the mask
    always_comb
        for (int i = 0; i < NUM_SECTORS; i++)
            guard[i] = lockdown_in[i] | (prot_en_out & (sect_sel_in[8*i+:8] == SECT_PROTECTED));
    always_ff @(posedge clock_in or negedge resetn_in)
        if (!resetn_in)
            busy_cnt <= '0;
        else
            busy_cnt <= busy_out ? busy_cnt + 16'h1 : 16'h0;
    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (!resetn_in);
    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    a_busy_cause: assert property ($rose(busy_out) |-> cs_n_in && $past(cs_n_in, 2))
        else $error("busy rose without a completed select");
    a_sect_onehot: assert property (op_valid_out && op_kind_out == OP_SECT |-> $onehot(op_sect_mask_out))
        else $error("sector erase mask not one-hot");
    a_word_hold: assert property (op_valid_out && !op_ready_in |=>
        op_valid_out && $stable(op_kind_out) && $stable(op_sect_mask_out) && $stable(op_page_out)
        && $stable(op_buf_out))
        else $error("operation word lost during stall");
    a_chip_skip: assert property (op_valid_out && op_kind_out == OP_CHIP |-> (op_sect_mask_out & guard) == '0)
        else $error("whole erase touches a guarded sector");
    a_pin_forces: assert property ((!wp_n_in && !busy_out) [*6] |-> prot_en_out)
        else $error("asserted protect pin not enforced");
    a_dis_ignored: assert property ((!wp_n_in) [*4] ##0 prot_en_out |=> prot_en_out)
        else $error("protection dropped with pin asserted");
    a_erase_frozen: assert property (busy_out && $past(busy_out) && $past(busy_out, 2) |-> $stable(prot_en_out))
        else $error("protection changed during erase");
    a_busy_len: assert property ($fell(busy_out) |-> $past(busy_cnt) >= CHIP_CYCLES)
        else $error("busy period too short");
    c_sect: cover property (op_valid_out && op_kind_out == OP_SECT);
    c_chip: cover property (op_valid_out && op_kind_out == OP_CHIP);
    c_prog: cover property (op_valid_out && op_kind_out == OP_PROG);
endmodule
bind fepp_core fepp_monitor #(.CHIP_CYCLES(CHIP_CYCLES)) mon (.clock_in(clock_in), .resetn_in(resetn_in),
    .cs_n_in(cs_n_in), .wp_n_in(wp_n_in), .sect_sel_in(sect_sel_in), .lockdown_in(lockdown_in),
    .busy_out(busy_out), .prot_en_out(prot_en_out), .op_valid_out(op_valid_out), .op_kind_out(op_kind_out),
    .op_sect_mask_out(op_sect_mask_out), .op_page_out(op_page_out), .op_buf_out(op_buf_out),
    .op_ready_in(op_ready_in));
`default_nettype wire

// >>> fepp_host.sv
// host serial controller model that frames commands for the sequencer
`timescale 1ns/1ps
`default_nettype none
module fepp_host (
    input wire logic clock_in, // system clock, paces the serial clock
    output logic cs_n_out, // chip select, active low
    output logic sck_out, // serial clock, still outside frames
    output logic si_out // serial data, msb first
);
    initial
    begin
        cs_n_out = 1'b1;
        sck_out = 1'b0;
        si_out = 1'b0;
    end
    // 200 ns serial period: four clocks low, four high
    task automatic send(input logic [7:0] b[$]);
        @(negedge clock_in);
        cs_n_out = 1'b0;
        foreach (b[i])
            for (int k = 7; k >= 0; k--)
            begin
                si_out = b[i][k];
                repeat (4) @(negedge clock_in);
                sck_out = 1'b1;
                repeat (4) @(negedge clock_in);
                sck_out = 1'b0;
            end
        repeat (4) @(negedge clock_in);
        cs_n_out = 1'b1;
        si_out = ~si_out; // released line must not keep its last value
        repeat (8) @(negedge clock_in);
    endtask
endmodule
`default_nettype wire

// >>> fepp_tb.sv
// self-checking bench for the flash command sequencer
`timescale 1ns/1ps
`default_nettype none
module fepp_tb;
    import fepp_pkg::*;
    localparam int CHIP_N = 50;
    logic clock_in, resetn_in, cs_n, sck, si, wp_n_in, page_256_in, op_ready_in;
    logic [127:0] sect_sel_in;
    logic [15:0] lockdown_in, op_sect_mask_out;
    logic [1:0] rd_buf_in;
    logic [8:0] rd_addr_in;
    logic busy_out, prot_en_out, op_valid_out, op_buf_out;
    logic [7:0] rd_data_out;
    logic [2:0] op_kind_out;
    logic [11:0] op_page_out;
    int n_mismatch, comparisons;
    fepp_host host (.clock_in(clock_in), .cs_n_out(cs_n), .sck_out(sck), .si_out(si));
    fepp_core #(.CHIP_CYCLES(CHIP_N)) dut (.clock_in(clock_in), .resetn_in(resetn_in), .cs_n_in(cs_n),
        .sck_in(sck), .si_in(si), .wp_n_in(wp_n_in), .page_256_in(page_256_in), .sect_sel_in(sect_sel_in),
        .lockdown_in(lockdown_in), .rd_buf_in(rd_buf_in), .rd_addr_in(rd_addr_in), .busy_out(busy_out),
        .prot_en_out(prot_en_out), .rd_data_out(rd_data_out), .op_valid_out(op_valid_out),
        .op_kind_out(op_kind_out), .op_sect_mask_out(op_sect_mask_out), .op_page_out(op_page_out),
        .op_buf_out(op_buf_out), .op_ready_in(op_ready_in));
    initial
    begin
        clock_in = 1'b0;
        forever #12.5 clock_in = ~clock_in;
    end
    task automatic cyc(input int n);
        repeat (n) @(negedge clock_in);
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic wait_op(input logic [2:0] kind);
        int n;
        n = 0;
        while (op_valid_out !== 1'b1 && n < 64)
        begin
            cyc(1);
            n++;
        end
        if (n == 64)
        begin
            n_mismatch++;
            close_out();
        end
        check(op_kind_out, kind);
    endtask
    // array side stalls three cycles, then takes the word and times busy
    task automatic take_op(input int min_n);
        int n;
        cyc(3);
        check(op_valid_out, 1'b1);
        op_ready_in = 1'b1;
        cyc(1);
        op_ready_in = 1'b0;
        check(op_valid_out, 1'b0);
        n = 0;
        while (busy_out === 1'b1 && n < 8000)
        begin
            cyc(1);
            n++;
        end
        if (n == 8000)
        begin
            n_mismatch++;
            close_out();
        end
        check(n >= min_n - 8, 1'b1);
    endtask
    task automatic t_short;
        host.send('{OP_SECTOR_ERASE, 8'h00});
        cyc(24);
        check(busy_out, 1'b0);
        check(op_valid_out, 1'b0);
        $display("test short command done");
    endtask
    task automatic t_sector;
        logic [11:0] pg[4] = '{12'h008, 12'h5A0, 12'hF37, 12'h003};
        int sc[4] = '{0, 5, 15, 0};
        logic [23:0] a;
        for (int i = 0; i < 4; i++)
        begin
            page_256_in = (i > 1);
            a = page_256_in ? {4'h0, pg[i], 8'h00} : {3'h0, pg[i], 9'h000};
            host.send('{OP_SECTOR_ERASE, a[23:16], a[15:8], a[7:0]});
            wait_op(OP_SECT);
            check(op_sect_mask_out, 16'h1 << sc[i]);
            take_op(ERASE_CYCLES);
        end
        $display("test sector erase done");
    endtask
    task automatic t_program;
        logic [8:0] ad[7] = '{9'h0FE, 9'h0FF, 9'h000, 9'h001, 9'h106, 9'h107, 9'h000};
        logic [7:0] dv[7] = '{8'hA1, 8'hB2, 8'hC3, 8'hD4, 8'h11, 8'h22, 8'h33};
        page_256_in = 1'b1;
        host.send('{OP_PROG_BUF2, 8'h01, 8'h23, 8'hFE, 8'hA1, 8'hB2, 8'hC3, 8'hD4});
        wait_op(OP_PROG);
        check(op_page_out, 12'h123);
        check(op_buf_out, 1'b1);
        take_op(ERASE_CYCLES + PROG_CYCLES);
        page_256_in = 1'b0;
        host.send('{OP_PROG_BUF1, 8'h01, 8'h57, 8'h06, 8'h11, 8'h22, 8'h33});
        wait_op(OP_PROG);
        check(op_page_out, 12'h0AB);
        check(op_buf_out, 1'b0);
        take_op(ERASE_CYCLES + PROG_CYCLES);
        for (int i = 0; i < 7; i++)
        begin
            rd_buf_in = (i < 4) ? 2'b10 : 2'b01;
            rd_addr_in = ad[i];
            cyc(2);
            check(rd_data_out, dv[i]);
        end
        $display("test page program done");
    endtask
    task automatic t_chip;
        page_256_in = 1'b1;
        sect_sel_in[8*7+:8] = SECT_PROTECTED;
        lockdown_in = 16'h0008;
        host.send('{SEQ_PROT_0, SEQ_PROT_1, SEQ_PROT_2, SEQ_PROT_EN});
        check(prot_en_out, 1'b1);
        host.send('{SEQ_CHIP_0, SEQ_CHIP_1, SEQ_CHIP_2, SEQ_CHIP_3, 8'h7C});
        wait_op(OP_CHIP);
        check(op_sect_mask_out, 16'hFF77);
        take_op(CHIP_N);
        host.send('{OP_PROG_BUF1, 8'h07, 8'h00, 8'h00, 8'h5A});
        cyc(24);
        check(busy_out, 1'b0);
        check(op_valid_out, 1'b0);
        lockdown_in = 16'h0000;
        $display("test whole erase done");
    endtask
    task automatic t_protect;
        wp_n_in = 1'b0;
        cyc(8);
        host.send('{SEQ_PROT_0, SEQ_PROT_1, SEQ_PROT_2, SEQ_PROT_DIS});
        check(prot_en_out, 1'b1);
        wp_n_in = 1'b1;
        cyc(8);
        check(prot_en_out, 1'b1);
        host.send('{SEQ_PROT_0, SEQ_PROT_1, SEQ_PROT_2, SEQ_PROT_DIS});
        check(prot_en_out, 1'b0);
        wp_n_in = 1'b0;
        cyc(8);
        check(prot_en_out, 1'b1);
        wp_n_in = 1'b1;
        cyc(8);
        check(prot_en_out, 1'b0);
        host.send('{OP_SECTOR_ERASE, 8'h05, 8'hA0, 8'h00});
        wait_op(OP_SECT);
        check(op_sect_mask_out, 16'h0020);
        wp_n_in = 1'b0;
        cyc(8);
        check(prot_en_out, 1'b0);
        take_op(ERASE_CYCLES - 8);
        cyc(8);
        check(prot_en_out, 1'b1);
        wp_n_in = 1'b1;
        cyc(8);
        $display("test protection done");
    endtask
    initial
    begin
        resetn_in = 1'b0;
        wp_n_in = 1'b1;
        page_256_in = 1'b0;
        op_ready_in = 1'b0;
        sect_sel_in = '0;
        lockdown_in = '0;
        rd_buf_in = 2'b01;
        rd_addr_in = '0;
        n_mismatch = 0;
        comparisons = 0;
        cyc(20);
        resetn_in = 1'b1;
        cyc(4);
        check(busy_out, 1'b0);
        check(prot_en_out, 1'b0);
        t_short();
        t_sector();
        t_program();
        t_chip();
        t_protect();
        close_out();
    end
endmodule
`default_nettype wire
